/* pkg/ccs_defines.svh */
`ifndef CCS_DEFINES_SVH
`define CCS_DEFINES_SVH
// ----------------------------------------
// Register addresses and fields
// ----------------------------------------
`define CCS_ADDR_CLKSRC   16'hffde
`define CCS_BIT_DONE      7
`define CCS_BIT_XWATCH    4
`define CCS_BIT_DBL       3
`define CCS_SEL_HI        2
`define CCS_SEL_LO        0
`define CCS_CFG2_DBL      7
`define CCS_TRIM_W        6
`define CCS_TRIM_CLOCK_OUTPUT_ENABLE    6
`define CCS_AUX_LPSAVE    7
// ----------------------------------------
// Source select encodings
// ----------------------------------------
`define CCS_SEL_XTAL      3'h0
`define CCS_SEL_EXTIN     3'h3
`define CCS_SEL_WDOSC     3'h4
`define CCS_SEL_RC        3'h7
// ----------------------------------------
// Rates and timing
// ----------------------------------------
`define CCS_RC_KHZ        7373
`define CCS_RC_DBL_KHZ    14746
`define CCS_WDOSC_KHZ     400
`define CCS_LPSAVE_KHZ    8000
`define CCS_CLK_MHZ       250
`define CCS_SETTLE_NS     1000
`define CCS_SETTLE_CYC    ((`CCS_SETTLE_NS * `CCS_CLK_MHZ) / 1000)
`endif

/* pkg/ccs_pkg.sv */
package ccs_pkg;
  typedef enum logic [1:0] {
    CCS_IDLE   = 2'b00,
    CCS_SETTLE = 2'b01,
    CCS_COMMIT = 2'b10
  } ccs_state_t;
endpackage

/* rtl/ccs_divided_clock_pin_div.sv */
`timescale 1ns/100ps
// ----------------------------------------
// Half-rate clock output generator
// ----------------------------------------
module ccs_divided_clock_pin_div (
  input  wire logic clk_sys_in,
  input  wire logic rst_n_in,
  input  wire logic core_tick_in,
  input  wire logic enable_in,
  output logic      div_clk_out
);
  logic div_ff;
  logic nxt_div;

  // Toggle on every core clock tick, so the output runs at half the core rate
  assign nxt_div = enable_in ? (div_ff ^ core_tick_in) : 1'b0;

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      div_ff <= 1'b0;
    end else begin
      div_ff <= nxt_div;
    end
  end

  assign div_clk_out = div_ff;
endmodule

/* rtl/ccs_clock_control.sv */
`timescale 1ns/100ps
`include "ccs_defines.svh"
// Behaviour
// - Clock output only while crystal unused
// - Trim register bit enables clock output
// - Clock output is half core clock
// - Six-bit trim loads factory value at reset
// - Doubler bit doubles RC oscillator rate
// - Power-save bit resets zero, slow clocks only
// - Watchdog oscillator selectable as core clock
// - Switch sources while code runs
// - Done flag clears on start, sets on completion
// - Writes ignored while done flag low
// - Reset value from user configuration bytes
// - Register at extended address, MOVX access
module ccs_clock_control #(
  // Settling time of a new source, about 1 us at the system clock rate
  parameter int          SETTLE_CYC   = `CCS_SETTLE_CYC,
  // Factory trim default is arbitrary; the real value comes from the device store
  parameter logic [5:0]  FACTORY_TRIM = 6'h20
) (
  input  wire logic       clk_sys_in,
  input  wire logic       rst_n_in,
  input  wire logic [7:0] user_config_byte_one_in,
  input  wire logic [7:0] user_config_byte_two_in,
  input  wire logic [15:0] xaddr_in,
  input  wire logic [7:0] xwdata_in,
  input  wire logic       xwr_in,
  input  wire logic       xrd_in,
  input  wire logic [6:0] trim_wdata_in,
  input  wire logic       trim_wr_in,
  input  wire logic       aux_lpsave_in,
  input  wire logic       aux_wr_in,
  input  wire logic       rtc_wdt_use_xtal_in,
  input  wire logic       core_tick_in,
  input  wire logic       port_pin_data_in,
  input  wire logic       port_pin_oe_n_in,
  output logic [7:0]      xrdata_out,
  output logic [6:0]      trim_out,
  output logic            low_speed_power_save_out,
  output logic [2:0]      core_source_sel_out,
  output logic            rate_doubler_select_out,
  output logic            switch_done_flag_out,
  output logic            second_crystal_pin_out,
  output logic            second_crystal_pin_oe_n_out
);
  import ccs_pkg::*;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  ccs_state_t  state_ff, nxt_state;
  logic [2:0]  sel_ff, nxt_sel;
  logic        dbl_ff, nxt_dbl;
  logic        xwatch_ff, nxt_xwatch;
  // Pending copies hold the new setting while the new source settles
  logic [2:0]  pend_sel_ff, nxt_pend_sel;
  logic        pend_dbl_ff, nxt_pend_dbl;
  logic        done_ff, nxt_done;
  logic [`CCS_TRIM_W-1:0] trim_ff, nxt_trim;
  logic        clock_output_enable_ff, nxt_clock_output_enable;
  logic        lpsave_ff, nxt_lpsave;
  logic        strap_ff;
  logic [15:0] cnt_ff, nxt_cnt;
  logic [7:0]  rdata_ff, nxt_rdata;

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  function automatic logic hit(input logic [15:0] a);
    hit = (a == `CCS_ADDR_CLKSRC);
  endfunction

  wire       src_wr    = xwr_in && hit(xaddr_in);
  wire       rd_hit    = xrd_in && hit(xaddr_in);
  // A write is taken only while no switch is in flight; the rest are dropped
  // without trace, so a half-finished switch is never disturbed
  wire       src_take  = src_wr && done_ff;
  wire [2:0] wr_sel    = xwdata_in[`CCS_SEL_HI:`CCS_SEL_LO];
  wire       wr_dbl    = xwdata_in[`CCS_BIT_DBL];
  wire       cnt_end   = (cnt_ff == 16'(SETTLE_CYC - 1));
  wire       xtal_core = (sel_ff == `CCS_SEL_XTAL);
  // Crystal counts as busy if the core, the RTC or the watchdog uses it, or the crystal watch bit is set
  wire       xtal_busy = xtal_core || rtc_wdt_use_xtal_in || xwatch_ff;
  // Rechecked every cycle, so a later RTC or watchdog claim on the crystal
  // takes the output away at once
  wire       clk_out_en = clock_output_enable_ff && !xtal_busy;
  wire       div_clk;

  // ----------------------------------------
  // Source switch sequencer
  // ----------------------------------------
  // A switch runs in three steps: the write is taken and done drops, the new
  // source gets SETTLE_CYC cycles to run stable, then select and doubler are
  // replaced together as done rises again
  always_comb begin
    nxt_state    = state_ff;
    nxt_sel      = sel_ff;
    nxt_dbl      = dbl_ff;
    nxt_xwatch   = xwatch_ff;
    nxt_pend_sel = pend_sel_ff;
    nxt_pend_dbl = pend_dbl_ff;
    nxt_done     = done_ff;
    nxt_cnt      = cnt_ff;
    unique case (state_ff)
      CCS_IDLE: begin
        if (strap_ff) begin
          // Load straps once after reset release
          nxt_sel = user_config_byte_one_in[`CCS_SEL_HI:`CCS_SEL_LO];
          nxt_dbl = user_config_byte_two_in[`CCS_CFG2_DBL];
        end else if (src_take) begin
          // The crystal watch bit acts at once, the select only after settling
          nxt_xwatch   = xwdata_in[`CCS_BIT_XWATCH];
          nxt_pend_sel = wr_sel;
          nxt_pend_dbl = wr_dbl;
          nxt_done     = 1'b0;
          nxt_cnt      = 16'h0000;
          nxt_state    = CCS_SETTLE;
        end
      end
      CCS_SETTLE: begin
        // New source must run stable before the glitch-free handover
        // The counter is 16 bits wide, so SETTLE_CYC must not exceed 65536
        nxt_cnt = cnt_ff + 16'h0001;
        if (cnt_end) begin
          nxt_state = CCS_COMMIT;
        end
      end
      CCS_COMMIT: begin
        // Select and doubler move on one edge, the core never sees a mix
        nxt_sel   = pend_sel_ff;
        nxt_dbl   = pend_dbl_ff;
        nxt_done  = 1'b1;
        nxt_state = CCS_IDLE;
      end
      default: begin
        // Unused state code: return to idle and reopen the register
        nxt_state = CCS_IDLE;
        nxt_done  = 1'b1;
      end
    endcase
  end

  // ----------------------------------------
  // Trim, power save, read data
  // ----------------------------------------
  // Trim and output enable share one write, as they live in one register
  assign nxt_trim   = trim_wr_in ? trim_wdata_in[`CCS_TRIM_W-1:0] : trim_ff;
  assign nxt_clock_output_enable  = trim_wr_in ? trim_wdata_in[`CCS_TRIM_CLOCK_OUTPUT_ENABLE] : clock_output_enable_ff;
  // Software must only set this for core clocks of 8 MHz or below
  assign nxt_lpsave = aux_wr_in ? aux_lpsave_in : lpsave_ff;
  // Read data is registered: it stands the cycle after the strobe, and any
  // other address reads zero
  assign nxt_rdata  = rd_hit ?
                      {done_ff, 2'b00, xwatch_ff, dbl_ff, sel_ff} : 8'h00;

  // ----------------------------------------
  // Sequencer registers
  // ----------------------------------------
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_ff <= CCS_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_ff <= 16'h0000;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  // Straps are sampled on the first edge after reset release, once the
  // configuration bytes are known to be settled; no write is taken on
  // that edge, so the strap load never races a software switch
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      strap_ff <= 1'b1;
    end else begin
      strap_ff <= 1'b0;
    end
  end

  // ----------------------------------------
  // Live and pending source selection
  // ----------------------------------------
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sel_ff <= 3'h0;
    end else begin
      sel_ff <= nxt_sel;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      dbl_ff <= 1'b0;
    end else begin
      dbl_ff <= nxt_dbl;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      xwatch_ff <= 1'b0;
    end else begin
      xwatch_ff <= nxt_xwatch;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pend_sel_ff <= 3'h0;
    end else begin
      pend_sel_ff <= nxt_pend_sel;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pend_dbl_ff <= 1'b0;
    end else begin
      pend_dbl_ff <= nxt_pend_dbl;
    end
  end

  // Done resets high so the first switch after reset is accepted
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      done_ff <= 1'b1;
    end else begin
      done_ff <= nxt_done;
    end
  end

  // ----------------------------------------
  // Trim, power save and read data registers
  // ----------------------------------------
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      trim_ff <= FACTORY_TRIM;
    end else begin
      trim_ff <= nxt_trim;
    end
  end

  // Clock output stays off after reset, so the pin starts as a port pin
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      clock_output_enable_ff <= 1'b0;
    end else begin
      clock_output_enable_ff <= nxt_clock_output_enable;
    end
  end

  // Power save resets off: full-speed access until software asks for it
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      lpsave_ff <= 1'b0;
    end else begin
      lpsave_ff <= nxt_lpsave;
    end
  end

  // Cleared in every cycle without a read, so stale data never lingers
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_ff <= 8'h00;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  // ----------------------------------------
  // Clock output pin
  // ----------------------------------------
  ccs_divided_clock_pin_div u_div (
    .clk_sys_in   (clk_sys_in),
    .rst_n_in     (rst_n_in),
    .core_tick_in (core_tick_in),
    .enable_in    (clk_out_en),
    .div_clk_out  (div_clk)
  );

  // The divider is held cleared while the output is off, so every enable
  // starts from a low level and first rises on the next core tick
  // Without the enable the pin stays with its port function
  assign second_crystal_pin_out      = clk_out_en ? div_clk : port_pin_data_in;
  assign second_crystal_pin_oe_n_out = clk_out_en ? 1'b0 : port_pin_oe_n_in;

  // ----------------------------------------
  // Register outputs
  // ----------------------------------------
  assign xrdata_out               = rdata_ff;
  assign trim_out                 = {clock_output_enable_ff, trim_ff};
  assign low_speed_power_save_out = lpsave_ff;
  assign core_source_sel_out      = sel_ff;
  assign rate_doubler_select_out  = dbl_ff;
  assign switch_done_flag_out     = done_ff;
endmodule

/* tb/ccs_clock_control_asserts.sv */
`timescale 1ns/100ps
// ----------------------------------------
// Port checks
// ----------------------------------------
module ccs_asserts (
  input wire logic        clk_sys_in,
  input wire logic        rst_n_in,
  input wire logic [15:0] xaddr_in,
  input wire logic [7:0]  xwdata_in,
  input wire logic        xwr_in,
  input wire logic        xrd_in,
  input wire logic        rtc_wdt_use_xtal_in,
  input wire logic        core_tick_in,
  input wire logic        port_pin_oe_n_in,
  input wire logic [7:0]  xrdata_out,
  input wire logic [6:0]  trim_out,
  input wire logic [2:0]  core_source_sel_out,
  input wire logic        rate_doubler_select_out,
  input wire logic        switch_done_flag_out,
  input wire logic        second_crystal_pin_out,
  input wire logic        second_crystal_pin_oe_n_out
);
  default clocking dc @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  wire hit  = xaddr_in == 16'hffde;
  wire done = switch_done_flag_out;
  logic xw_ff;
  // The crystal watch bit is no port: mirror it from accepted writes
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      xw_ff <= 1'b0;
    end else if (xwr_in && hit && done) begin
      xw_ff <= xwdata_in[4];
    end
  end
  wire xok  = trim_out[6] && core_source_sel_out != 3'h0 && !rtc_wdt_use_xtal_in && !xw_ff;
  // Sized for SETTLE_CYC of 4
  sequence s_busy; !done [*5]; endsequence
  sequence s_back; done; endsequence
  property p_settle; xwr_in && hit && done |=> s_busy ##1 s_back; endproperty
  a_settle: assert property (p_settle) else $error("switch timing");
  property p_sel; $changed(core_source_sel_out) && $past(rst_n_in, 2) |-> $rose(done); endproperty
  a_sel: assert property (p_sel) else $error("select moved");
  property p_dbl; $changed(rate_doubler_select_out) && $past(rst_n_in, 2) |-> $rose(done);
  endproperty
  a_dbl: assert property (p_dbl) else $error("doubler moved");
  property p_rdz; xrdata_out != 8'h00 |-> $past(xrd_in) && $past(xaddr_in) == 16'hffde; endproperty
  a_rdz: assert property (p_rdz) else $error("stray read data");
  property p_rdd; xrd_in && hit |=> xrdata_out[7:5] == {$past(done), 2'h0} &&
    xrdata_out[4] == $past(xw_ff) &&
    xrdata_out[3:0] == {$past(rate_doubler_select_out), $past(core_source_sel_out)}; endproperty
  a_rdd: assert property (p_rdd) else $error("read data");
  property p_gate; port_pin_oe_n_in && $past(port_pin_oe_n_in) && !second_crystal_pin_oe_n_out
    |-> xok || $past(xok); endproperty
  a_gate: assert property (p_gate) else $error("pin driven");
  property p_tog; xok && $past(xok) && core_tick_in |-> ##[0:1] $changed(second_crystal_pin_out);
  endproperty
  a_tog: assert property (p_tog) else $error("no toggle");
  property p_hold; xok && $past(xok) && !core_tick_in && !$past(core_tick_in)
    |-> $stable(second_crystal_pin_out); endproperty
  a_hold: assert property (p_hold) else $error("extra toggle");
endmodule

/* tb/ccs_ext_sink.sv */
`timescale 1ns/100ps
// Device clocked from the pin; a released pin clocks nothing
module ccs_ext_sink (
  input  wire logic pin_in,
  input  wire logic oe_n_in,
  output logic [7:0] rises_out
);
  logic [7:0] rise_cnt = 8'h00;
  always @(posedge pin_in) begin
    if (!oe_n_in) begin
      rise_cnt <= rise_cnt + 8'h01;
    end
  end
  assign rises_out = rise_cnt;
endmodule

/* tb/tb_core_clock_source_control.sv */
`timescale 1ns/100ps
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin error_cnt++; \
  $display("wrong value %s exp %h got %h", n, e, g); end end
module tb_core_clock_source_control;
  logic        clk_sys_in = 0;
  logic        rst_n_in = 0;
  logic [7:0]  user_config_byte_one_in = 8'h2f;
  logic [7:0]  user_config_byte_two_in = 8'h80;
  logic [15:0] xaddr_in = 16'h0000;
  logic [7:0]  xwdata_in = 8'h00;
  logic [6:0]  trim_wdata_in = 7'h00;
  logic        xwr_in = 0, xrd_in = 0, trim_wr_in = 0, aux_lpsave_in = 0, aux_wr_in = 0;
  logic        rtc_wdt_use_xtal_in = 0, core_tick_in = 0;
  logic        port_pin_data_in = 0, port_pin_oe_n_in = 1;
  logic [7:0]  xrdata_out, r, k, rises;
  logic [6:0]  trim_out;
  logic [2:0]  core_source_sel_out;
  logic        low_speed_power_save_out, rate_doubler_select_out, switch_done_flag_out;
  logic        second_crystal_pin_out, second_crystal_pin_oe_n_out;
  logic [7:0]  src [5] = '{8'h04, 8'h03, 8'h0f, 8'h00, 8'h07};
  int          error_cnt = 0, n_tests = 0;
  ccs_clock_control #(.SETTLE_CYC(4)) uut (.*);
  ccs_ext_sink sink (.pin_in(second_crystal_pin_out), .oe_n_in(second_crystal_pin_oe_n_out),
    .rises_out(rises));
  always #2 clk_sys_in = ~clk_sys_in;
  task automatic test_done;
    $display("errors %0d checks %0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    xaddr_in  <= a;
    xwdata_in <= d;
    xwr_in    <= 1'b1;
    @(posedge clk_sys_in);
    xwr_in    <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a);
    @(posedge clk_sys_in);
    xaddr_in <= a;
    xrd_in   <= 1'b1;
    @(posedge clk_sys_in);
    xrd_in   <= 1'b0;
    #1 r = xrdata_out;
  endtask
  task automatic wait_done;
    for (int i = 0; i < 20; i++) begin
      @(posedge clk_sys_in);
      #1;
      if (switch_done_flag_out === 1'b1) break;
    end
    if (switch_done_flag_out !== 1'b1) begin
      error_cnt++;
      test_done();
    end
  endtask
  task automatic tick;
    @(posedge clk_sys_in);
    #1;
  endtask
  initial begin
    repeat (6) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    repeat (2) tick();
    `CHK("sel", 3'h7, core_source_sel_out)
    `CHK("dbl", 1'b1, rate_doubler_select_out)
    `CHK("trim", 7'h20, trim_out)
    `CHK("lps", 1'b0, low_speed_power_save_out)
    rd(16'hffde);
    `CHK("rd", 8'h8f, r)
    rd(16'hffdd);
    `CHK("rd other", 8'h00, r)
    wr(16'hffdf, 8'h04);
    tick();
    `CHK("done", 1'b1, switch_done_flag_out)
    foreach (src[i]) begin
      wr(16'hffde, src[i]);
      tick();
      `CHK("busy", 1'b0, switch_done_flag_out)
      wr(16'hffde, 8'h0b);
      wait_done();
      `CHK("sel", src[i][2:0], core_source_sel_out)
      `CHK("dbl", src[i][3], rate_doubler_select_out)
    end
    // Power save only now, the core runs at the undoubled RC rate
    @(posedge clk_sys_in);
    trim_wdata_in <= 7'h55;
    trim_wr_in    <= 1'b1;
    aux_lpsave_in <= 1'b1;
    aux_wr_in     <= 1'b1;
    @(posedge clk_sys_in);
    trim_wr_in    <= 1'b0;
    aux_wr_in     <= 1'b0;
    k = rises;
    repeat (16) begin
      @(posedge clk_sys_in);
      core_tick_in <= 1'b1;
      @(posedge clk_sys_in);
      core_tick_in <= 1'b0;
    end
    repeat (2) tick();
    `CHK("trim", 7'h55, trim_out)
    `CHK("lps", 1'b1, low_speed_power_save_out)
    `CHK("rises", k + 8'h08, rises)
    rtc_wdt_use_xtal_in <= 1'b1;
    port_pin_data_in    <= 1'b1;
    repeat (2) tick();
    `CHK("oe_n", 1'b1, second_crystal_pin_oe_n_out)
    `CHK("pin", 1'b1, second_crystal_pin_out)
    rtc_wdt_use_xtal_in <= 1'b0;
    wr(16'hffde, 8'h17);
    wait_done();
    `CHK("oe_n watch", 1'b1, second_crystal_pin_oe_n_out)
    rd(16'hffde);
    `CHK("rd watch", 8'h97, r)
    wr(16'hffde, 8'h00);
    wait_done();
    `CHK("oe_n xtal", 1'b1, second_crystal_pin_oe_n_out)
    test_done();
  end
endmodule
bind ccs_clock_control ccs_asserts u_chk (
  .clk_sys_in                  (clk_sys_in),
  .rst_n_in                    (rst_n_in),
  .xaddr_in                    (xaddr_in),
  .xwdata_in                   (xwdata_in),
  .xwr_in                      (xwr_in),
  .xrd_in                      (xrd_in),
  .rtc_wdt_use_xtal_in         (rtc_wdt_use_xtal_in),
  .core_tick_in                (core_tick_in),
  .port_pin_oe_n_in            (port_pin_oe_n_in),
  .xrdata_out                  (xrdata_out),
  .trim_out                    (trim_out),
  .core_source_sel_out         (core_source_sel_out),
  .rate_doubler_select_out     (rate_doubler_select_out),
  .switch_done_flag_out        (switch_done_flag_out),
  .second_crystal_pin_out      (second_crystal_pin_out),
  .second_crystal_pin_oe_n_out (second_crystal_pin_oe_n_out)
);
